// ===== inc/cmd_bus_regs.vh
// Constants for the serial command bus interpreter
`ifndef CMD_BUS_REGS_VH
`define CMD_BUS_REGS_VH
`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define HALF_BIT_CYCLES (`BIT_CYCLES / 2)
`define BITS_PER_CHAR 10
`define GAP_BYTES 3
`define GAP_BITS (`GAP_BYTES * `BITS_PER_CHAR + 1)
`define GAP_CYCLES (`GAP_BITS * `BIT_CYCLES)
`define CNT_W 20
`define ADDR_MSB 7
`define ADDR_LSB 3
`define MODE_MSB 2
`define MODE_LSB 1
`define CODE_MSB 7
`define CODE_LSB 4
`define GLOBAL_ADDR 5'h1f
`define GROUP_LO 5'h10
`define GROUP_HI 5'h19
`define GROUP_RESET 5'h00
`define MODE_PARAM 2'h0
`define MODE_SETRST 2'h1
`define MODE_DIRECT 2'h2
`define MODE_STATUS 2'h3
`define REPLY_W 10
`define REPLY_BYTES 2
`define APB_CTRL 8'h00
`define APB_GROUP 8'h04
`define APB_STATUS 8'h08
`define APB_REPLY 8'h0c
`define APB_CMD 8'h10
`endif

// ===== hw/cmd_buf2.v
// Two-entry buffer with valid and ready on both sides
module cmd_buf2 (
  input wire clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [23:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [23:0] out_data
);
  reg [23:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule

// ===== hw/cmd_bus.v
// Serial command bus interpreter with status reply and APB registers
`include "cmd_bus_regs.vh"
module cmd_bus #(
  parameter BIT_LEN = `BIT_CYCLES
) (
  input wire clk,
  input wire srst,
  input wire rxd,
  output reg txd_ff,
  input wire slot_serial_receive_line,
  output reg slot_serial_transmit_line_ff,
  input wire [3:0] addr_switch,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  output reg cmd_valid_ff,
  output reg [1:0] cmd_mode_ff,
  output reg [3:0] cmd_code_ff,
  output reg [11:0] cmd_arg_ff
);
  // Bit time defaults to 9600 baud; a parameter so short runs stay possible
  localparam HALF_LEN = BIT_LEN / 2;
  localparam GAP_LEN = `GAP_BITS * BIT_LEN;
  // ********************************
  // Input synchronisers
  // ********************************
  reg [1:0] rx_s1_ff;
  reg [1:0] rx_s2_ff;
  reg [3:0] sw_s1_ff;
  reg [3:0] sw_s2_ff;
  wire rx_line;
  always @(posedge clk) begin
    if (srst) begin
      rx_s1_ff <= 2'h3;
      rx_s2_ff <= 2'h3;
      sw_s1_ff <= 4'h0;
      sw_s2_ff <= 4'h0;
    end else begin
      rx_s1_ff <= {slot_serial_receive_line, rxd};
      rx_s2_ff <= rx_s1_ff;
      sw_s1_ff <= addr_switch;
      sw_s2_ff <= sw_s1_ff;
    end
  end
  // Both idle high, so a wired AND merges the two receive paths
  assign rx_line = rx_s2_ff[0] & rx_s2_ff[1];
  // ********************************
  // Registers
  // ********************************
  reg rx_en_ff;
  reg tx_en_ff;
  reg [4:0] group_ff;
  reg [9:0] reply_ff;
  reg [7:0] drop_cnt_ff;
  // ********************************
  // Receiver
  // ********************************
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rx_st_ff;
  reg [`CNT_W-1:0] rx_cnt_ff;
  reg [2:0] rx_bit_ff;
  reg [7:0] rx_sh_ff;
  reg [`CNT_W-1:0] gap_cnt_ff;
  reg [1:0] byte_idx_ff;
  reg [15:0] hold_ff;
  reg byte_done;
  reg frame_ok;
  always @(posedge clk) begin
    if (srst) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= {`CNT_W{1'b0}};
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
    end else begin
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= {`CNT_W{1'b0}};
          if (!rx_line && rx_en_ff)
            rx_st_ff <= RX_START;
        end
        RX_START: begin
          if (rx_cnt_ff == HALF_LEN - 1) begin
            rx_cnt_ff <= {`CNT_W{1'b0}};
            rx_bit_ff <= 3'h0;
            rx_st_ff <= rx_line ? RX_IDLE : RX_DATA;
          end else
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
        end
        RX_DATA: begin
          if (rx_cnt_ff == BIT_LEN - 1) begin
            rx_cnt_ff <= {`CNT_W{1'b0}};
            rx_sh_ff <= {rx_line, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7)
              rx_st_ff <= RX_STOP;
          end else
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
        end
        RX_STOP: begin
          if (rx_cnt_ff == BIT_LEN - 1) begin
            rx_cnt_ff <= {`CNT_W{1'b0}};
            rx_st_ff <= RX_IDLE;
          end else
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end
  always @* begin
    byte_done = (rx_st_ff == RX_STOP) && (rx_cnt_ff == BIT_LEN - 1);
    frame_ok = byte_done && rx_line; // no parity, one stop bit
  end
  // ********************************
  // Command assembly and decode
  // ********************************
  wire [4:0] dst = hold_ff[`ADDR_MSB+8:`ADDR_LSB+8];
  wire own_hit = (dst[4] == 1'b0) && (dst[3:0] == sw_s2_ff);
  wire glob_hit = (dst == `GLOBAL_ADDR);
  wire grp_hit = (group_ff != `GROUP_RESET) && (dst == group_ff);
  wire addr_hit = own_hit || glob_hit || grp_hit;
  wire last_byte = frame_ok && (byte_idx_ff == 2'h2);
  wire buf_in_ready;
  wire buf_out_valid;
  wire [23:0] buf_out_data;
  reg buf_push;
  wire gap_seen = (gap_cnt_ff >= GAP_LEN);
  always @* begin
    // Foreign address or bad first marker bit drops the command
    buf_push = last_byte && addr_hit && hold_ff[8];
  end
  always @(posedge clk) begin
    if (srst) begin
      gap_cnt_ff <= {`CNT_W{1'b0}};
      byte_idx_ff <= 2'h3;
      hold_ff <= 16'h0000;
      drop_cnt_ff <= 8'h00;
    end else begin
      if (rx_st_ff != RX_IDLE || !rx_line)
        gap_cnt_ff <= {`CNT_W{1'b0}};
      else if (!gap_seen)
        gap_cnt_ff <= gap_cnt_ff + 1'b1;
      if (gap_seen && byte_idx_ff != 2'h0) begin
        // Partial command cut by idle gap is dropped
        if (byte_idx_ff != 2'h3)
          drop_cnt_ff <= drop_cnt_ff + 8'h01;
        byte_idx_ff <= 2'h0;
      end else if (byte_done && !frame_ok)
        byte_idx_ff <= 2'h3;
      else if (frame_ok && byte_idx_ff != 2'h3) begin
        hold_ff <= {hold_ff[7:0], rx_sh_ff};
        byte_idx_ff <= (byte_idx_ff == 2'h2) ? 2'h3 : byte_idx_ff + 2'h1;
        if (last_byte && !buf_push)
          drop_cnt_ff <= drop_cnt_ff + 8'h01;
      end
    end
  end
  // Buffer keeps a second command while cmd_valid_ff is still high for the first
  cmd_buf2 u_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data({hold_ff, rx_sh_ff}),
    .out_valid(buf_out_valid),
    .out_ready(!cmd_valid_ff),
    .out_data(buf_out_data)
  );
  reg cmd_take;
  reg reply_req_ff;
  always @* begin
    cmd_take = buf_out_valid && !cmd_valid_ff;
  end
  always @(posedge clk) begin
    if (srst) begin
      cmd_valid_ff <= 1'b0;
      cmd_mode_ff <= `MODE_PARAM;
      cmd_code_ff <= 4'h0;
      cmd_arg_ff <= 12'h000;
      reply_req_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= cmd_take;
      reply_req_ff <= 1'b0;
      if (cmd_take) begin
        cmd_mode_ff <= buf_out_data[`MODE_MSB+16:`MODE_LSB+16];
        cmd_code_ff <= buf_out_data[`CODE_MSB+8:`CODE_LSB+8];
        cmd_arg_ff <= {buf_out_data[11:8], buf_out_data[7:0]};
        reply_req_ff <= (buf_out_data[`MODE_MSB+16:`MODE_LSB+16] == `MODE_STATUS);
      end
    end
  end
  // ********************************
  // Reply transmitter
  // ********************************
  // Ten reply bits go as two characters, low byte first
  reg [`CNT_W-1:0] tx_cnt_ff;
  reg [3:0] tx_bit_ff;
  reg [9:0] tx_sh_ff;
  reg tx_busy_ff;
  reg tx_second_ff;
  reg [7:0] tx_hi_ff;
  always @(posedge clk) begin
    if (srst) begin
      txd_ff <= 1'b1;
      slot_serial_transmit_line_ff <= 1'b1;
      tx_cnt_ff <= {`CNT_W{1'b0}};
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 10'h3ff;
      tx_busy_ff <= 1'b0;
      tx_second_ff <= 1'b0;
      tx_hi_ff <= 8'h00;
    end else begin
      txd_ff <= tx_sh_ff[0] | ~tx_en_ff;
      slot_serial_transmit_line_ff <= tx_sh_ff[0] | ~tx_en_ff;
      if (!tx_busy_ff) begin
        if (reply_req_ff && tx_en_ff) begin
          tx_sh_ff <= {1'b1, reply_ff[7:0], 1'b0};
          tx_hi_ff <= {6'h00, reply_ff[9:8]};
          tx_second_ff <= 1'b1;
          tx_busy_ff <= 1'b1;
          tx_cnt_ff <= {`CNT_W{1'b0}};
          tx_bit_ff <= 4'h0;
        end
      end else if (tx_cnt_ff == BIT_LEN - 1) begin
        tx_cnt_ff <= {`CNT_W{1'b0}};
        tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
        if (tx_bit_ff == `BITS_PER_CHAR - 1) begin
          tx_bit_ff <= 4'h0;
          if (tx_second_ff) begin
            tx_sh_ff <= {1'b1, tx_hi_ff, 1'b0};
            tx_second_ff <= 1'b0;
          end else
            tx_busy_ff <= 1'b0;
        end else
          tx_bit_ff <= tx_bit_ff + 4'h1;
      end else
        tx_cnt_ff <= tx_cnt_ff + 1'b1;
    end
  end
  // ********************************
  // APB slave
  // ********************************
  wire acc = psel && penable && !pready_ff;
  wire grp_ok = (pwdata[4:0] >= `GROUP_LO) && (pwdata[4:0] <= `GROUP_HI);
  always @(posedge clk) begin
    if (srst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      rx_en_ff <= 1'b1;
      tx_en_ff <= 1'b1;
      group_ff <= `GROUP_RESET;
      reply_ff <= 10'h000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      if (acc) begin
        case (paddr)
          `APB_CTRL: begin
            if (pwrite) begin
              rx_en_ff <= pwdata[0];
              tx_en_ff <= pwdata[1];
            end else
              prdata_ff <= {30'h0, tx_en_ff, rx_en_ff};
          end
          `APB_GROUP: begin
            // A write clears the group unless the value lies in the group range
            if (pwrite)
              group_ff <= grp_ok ? pwdata[4:0] : `GROUP_RESET;
            else
              prdata_ff <= {27'h0, group_ff};
          end
          `APB_STATUS: begin
            if (!pwrite)
              prdata_ff <= {16'h0, drop_cnt_ff, 3'h0, sw_s2_ff, tx_busy_ff};
          end
          `APB_REPLY: begin
            if (pwrite)
              reply_ff <= pwdata[9:0];
            else
              prdata_ff <= {22'h0, reply_ff};
          end
          `APB_CMD: begin
            if (!pwrite)
              prdata_ff <= {13'h0, buf_in_ready, cmd_mode_ff, cmd_code_ff,
                cmd_arg_ff};
          end
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end
endmodule

// ===== tb/cmd_bus_chk.sv
// Assertion checker for the serial command bus interpreter
module cmd_bus_chk #(
  parameter int BIT_LEN = 10416
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic txd_ff,
  input wire logic slot_serial_transmit_line_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic cmd_valid_ff,
  input wire logic [1:0] cmd_mode_ff,
  input wire logic [3:0] cmd_code_ff,
  input wire logic [11:0] cmd_arg_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Saturates so a stuck line cannot wrap into a legal length
  logic [15:0] low_ff;
  always @(posedge clk) begin
    if (srst || txd_ff) low_ff <= 16'h0;
    else if (low_ff != 16'hffff) low_ff <= low_ff + 16'h1;
  end
  sequence s_access;
    psel && penable && !pready_ff;
  endsequence
  sequence s_answer;
    pready_ff ##1 !pready_ff;
  endsequence
  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("apb answer missing or too long");
  a_ready_cause: assert property (pready_ff |-> $past(psel && penable))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("pslverr without pready");
  a_valid_pulse: assert property (cmd_valid_ff |=> !cmd_valid_ff [*8])
    else $error("command pulse too long");
  a_fields_hold: assert property (
    $changed({cmd_mode_ff, cmd_code_ff, cmd_arg_ff}) |-> cmd_valid_ff)
    else $error("fields changed without command");
  a_tx_mirror: assert property (
    $changed(txd_ff) |-> ##[0:1] (slot_serial_transmit_line_ff == txd_ff))
    else $error("slot transmit line differs");
  a_tx_bit_len: assert property ($rose(txd_ff) |-> low_ff >= BIT_LEN)
    else $error("transmit low run shorter than a bit");
  a_reply_start: assert property (
    cmd_valid_ff && cmd_mode_ff == 2'h3 |-> ##[1:20] !txd_ff)
    else $error("status reply did not start");
endmodule
bind cmd_bus cmd_bus_chk #(.BIT_LEN(BIT_LEN)) i_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .txd_ff(txd_ff),
  .slot_serial_transmit_line_ff(slot_serial_transmit_line_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .cmd_valid_ff(cmd_valid_ff), .cmd_mode_ff(cmd_mode_ff),
  .cmd_code_ff(cmd_code_ff), .cmd_arg_ff(cmd_arg_ff)
);

// ===== tb/host_model.sv
// Host computer model: sends framed commands and receives replies
module host_model #(
  parameter int BIT = 10416
) (
  input wire logic clk,
  input wire logic line_in,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  task automatic send_cmd(input logic [7:0] b1, b2, b3, input int n);
    rxd <= 1'b1;
    repeat (32 * BIT) @(posedge clk);
    send_byte(b1);
    if (n > 1) send_byte(b2);
    if (n > 2) send_byte(b3);
  endtask
  // Waits bounded; a missing reply then shows as wrong data
  task automatic get_byte(output logic [7:0] b);
    int k;
    k = 0;
    // Reply follows the whole command, so the wait spans gap and three bytes
    while (line_in !== 1'b0 && k < 80 * BIT) begin
      @(posedge clk);
      k++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
  endtask
endmodule

// ===== tb/projector_serial_command_bus_tb_top.sv
// Self-checking testbench for the serial command bus interpreter
module projector_serial_command_bus_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] sw = 4'h0;
  logic rxd;
  // Short bit time keeps the run small; the design defaults to 9600 baud
  localparam int BIT = 16;
  logic sel_slot = 1'b0;
  wire txd_ff, slot_tx, pready_ff, pslverr_ff, cmd_valid_ff;
  wire [31:0] prdata_ff;
  wire [1:0] cmd_mode_ff;
  wire [3:0] cmd_code_ff;
  wire [11:0] cmd_arg_ff;
  int failures = 0;
  int n_tests = 0;
  int n_cmd = 0;
  logic [31:0] rd;
  logic err;
  logic [4:0] grp;
  logic [9:0] rep;
  always #5 clk = ~clk;
  always @(posedge clk) if (cmd_valid_ff === 1'b1) n_cmd <= n_cmd + 1;
  cmd_bus #(.BIT_LEN(BIT)) i_dut (
    .clk(clk), .srst(srst), .rxd(sel_slot ? 1'b1 : rxd), .txd_ff(txd_ff),
    .slot_serial_receive_line(sel_slot ? rxd : 1'b1),
    .slot_serial_transmit_line_ff(slot_tx), .addr_switch(sw), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .cmd_valid_ff(cmd_valid_ff), .cmd_mode_ff(cmd_mode_ff), .cmd_code_ff(cmd_code_ff),
    .cmd_arg_ff(cmd_arg_ff)
  );
  host_model #(.BIT(BIT)) host (.clk(clk), .line_in(txd_ff), .rxd(rxd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("failures %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    while (pready_ff !== 1'b1) @(posedge clk);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic bit hit(input logic [4:0] a);
    return a == {1'b0, sw} || a == 5'h1f || a == grp;
  endfunction
  task automatic run(input logic [4:0] a, input logic [1:0] m, input int n);
    logic [7:0] b1, b2, b3, r0, r1;
    int c;
    b1 = {a, m, 1'b1};
    b2 = 8'($urandom);
    b3 = 8'($urandom);
    c = n_cmd;
    fork
      host.send_cmd(b1, b2, b3, n);
      if (m == 2'h3 && hit(a)) begin
        host.get_byte(r0);
        host.get_byte(r1);
        check({16'h0, r1, r0}, {22'h0, rep});
      end
    join
    repeat (100) @(posedge clk);
    check(n_cmd - c, (n == 3 && hit(a)) ? 1 : 0);
    if (n == 3 && hit(a))
      check({14'h0, cmd_mode_ff, cmd_code_ff, cmd_arg_ff}, {14'h0, m, b2, b3});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h83e2));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    sw <= 4'($urandom);
    grp = 5'h10 + 5'($urandom_range(9, 0));
    rep = 10'($urandom);
    @(posedge clk);
    check(txd_ff, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd[1:0], 2'h3);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd[1:0], 2'h1);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h1a);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[4:0], 5'h00);
    apb(1'b1, 8'h04, {27'h0, grp});
    apb(1'b0, 8'h04, 32'h0);
    check(rd[4:0], grp);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 8'h0c, {22'h0, rep});
    apb(1'b0, 8'h08, 32'h0);
    check(rd[4:1], sw);
    for (int m = 0; m < 3; m++) run({1'b0, sw}, 2'(m), 3);
    // Global command arrives on the slot receive line instead
    sel_slot <= 1'b1;
    run(5'h1f, 2'h1, 3);
    sel_slot <= 1'b0;
    run(grp, 2'h2, 3);
    run({1'b0, sw ^ 4'h1}, 2'h0, 3);
    run({1'b0, sw}, 2'h0, 1);
    run({1'b0, sw}, 2'h3, 3);
    apb(1'b0, 8'h08, 32'h0);
    check(rd[15:8], 8'h02);
    give_verdict;
  end
  // Eight commands of about 1100 cycles each; limit leaves ample margin
  initial begin
    #500_000;
    failures++;
    give_verdict;
  end
endmodule
